// [rtl/spsc_regs.vh]
// Constants for the page stack control block: SFR addresses, fields, resets.
// Assumes an 8-bit SFR bus with a separate page select held by this block.
// Function
// - Control register decoded at 0xCF, all pages
// - Bit 0 enables auto paging, resets 1
// - Bits 6:4 index selects readout level only
// - Index 000..100 select levels; others invalid
// - Enabled interrupt entry pushes current page
// - Entry loads page of interrupting flag
// - Enabled return pops stack into current page
// - Push shifts each level one toward bottom
// - Stack moves only on entry and return
// - Readout read-only at 0xD3 page F
`ifndef SPSC_REGS_VH
`define SPSC_REGS_VH
// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define SPSC_ADDR_CTRL 8'hcf
`define SPSC_ADDR_READOUT 8'hd3
`define SPSC_ADDR_PAGE 8'ha7
`define SPSC_PAGE_F 8'h0f
// ----------------------------------------------------------------
// Fields and resets
// ----------------------------------------------------------------
`define SPSC_STACK_DEPTH 5
`define SPSC_EN_BIT 0
`define SPSC_IDX_LO 4
`define SPSC_IDX_HI 6
`define SPSC_EN_RESET 1'b1
`define SPSC_IDX_RESET 3'h0
`define SPSC_PAGE_RESET 8'h00
`define SPSC_IDX_MAX 3'h4
`endif

// [rtl/spsc_level_mux.v]
// Selects one level of the page stack for the readout register.
// Assumes levels packed top first, eight bits each.
`timescale 1ns/1ps
`include "spsc_regs.vh"
module spsc_level_mux #(
    parameter W = 8,
    parameter LEVELS = 5
) (
    input wire [W*LEVELS-1:0] i_levels,
    input wire [2:0] i_index,
    output reg [W-1:0] o_level
);
    integer k;
    always @* begin
        o_level = {W{1'b0}};
        // Invalid codes read as zero rather than aliasing a level
        for (k = 0; k < LEVELS; k = k + 1) begin
            if (i_index == k[2:0]) begin
                o_level = i_levels[k*W +: W];
            end
        end
    end
endmodule // spsc_level_mux

// [rtl/spsc_page_stack.v]
// SFR page stack with control register and readout register.
// Assumes the core gives one-cycle entry and return pulses, a page for
// the interrupting source, and a synchronous SFR read/write port.
`timescale 1ns/1ps
`include "spsc_regs.vh"
module spsc_page_stack #(
    parameter W = 8
) (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire [7:0] i_sfr_addr,
    input wire i_sfr_wr,
    input wire i_sfr_rd,
    input wire [7:0] i_sfr_wdata,
    input wire i_isr_enter,
    input wire [W-1:0] i_isr_page,
    input wire i_isr_return,
    output reg [7:0] o_sfr_rdata,
    output reg o_sfr_hit,
    output reg [W-1:0] o_current_page_select,
    output reg o_auto_page_enable
);
    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    // The page register is the top level; only the levels below it are
    // stored here, level one in the lowest bits, the bottom in the highest.
    localparam DEPTH = `SPSC_STACK_DEPTH;
    localparam STORED = DEPTH - 1;
    localparam SW = W * STORED;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // One comparator shape for every register decode
    function addr_match;
        input [7:0] addr;
        input [7:0] reg_addr;
        begin
            addr_match = (addr == reg_addr);
        end
    endfunction

    // Control byte as read back; reserved bits 7 and 3:1 read zero
    function [7:0] ctrl_byte;
        input en;
        input [2:0] idx;
        begin
            ctrl_byte = 8'h00;
            ctrl_byte[`SPSC_EN_BIT] = en;
            ctrl_byte[`SPSC_IDX_HI:`SPSC_IDX_LO] = idx;
        end
    endfunction

    // Push: every stored level moves one place down, the old top enters
    // level one and the bottom level falls off.
    function [SW-1:0] push_levels;
        input [SW-1:0] lv;
        input [W-1:0] top;
        begin
            push_levels = {lv[SW-W-1:0], top};
        end
    endfunction

    // Pop: every stored level moves one place up; the bottom keeps its
    // value, so popping past the bottom repeats the oldest page.
    function [SW-1:0] pop_levels;
        input [SW-1:0] lv;
        begin
            pop_levels = {lv[SW-1 -: W], lv[SW-1:W]};
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg auto_page_enable_r;
    reg auto_page_enable_nxt;
    reg [2:0] stack_level_index_r;
    reg [2:0] stack_level_index_nxt;
    reg [W-1:0] page_r;
    reg [W-1:0] page_nxt;
    reg [SW-1:0] lvl_r;
    reg [SW-1:0] lvl_nxt;
    reg [7:0] rdata_nxt;
    reg hit_nxt;
    wire [W*DEPTH-1:0] levels;
    wire [W-1:0] level_sel;
    wire hit_ctrl;
    wire hit_read;
    wire hit_page;
    wire ctrl_wr;
    wire page_wr;
    wire push_ev;
    wire pop_ev;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Control and page registers answer whatever page is selected
    assign hit_ctrl = addr_match(i_sfr_addr, `SPSC_ADDR_CTRL);
    assign hit_page = addr_match(i_sfr_addr, `SPSC_ADDR_PAGE);
    // The readout address belongs to another register on other pages
    assign hit_read = addr_match(i_sfr_addr, `SPSC_ADDR_READOUT)
        && (page_r == `SPSC_PAGE_F);
    assign ctrl_wr = i_sfr_wr && hit_ctrl;
    assign page_wr = i_sfr_wr && hit_page;
    // Entry outranks return if the core ever raises both together
    assign push_ev = auto_page_enable_r && i_isr_enter;
    assign pop_ev = auto_page_enable_r && i_isr_return && !i_isr_enter;
    assign levels = {lvl_r, page_r};

    // ----------------------------------------------------------------
    // Level select
    // ----------------------------------------------------------------
    spsc_level_mux #(
        .W(W),
        .LEVELS(DEPTH)
    ) u_mux (
        .i_levels(levels),
        .i_index(stack_level_index_r),
        .o_level(level_sel)
    );

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always @* begin
        auto_page_enable_nxt = auto_page_enable_r;
        stack_level_index_nxt = stack_level_index_r;
        if (ctrl_wr) begin
            // Reserved bits are dropped here and never stored
            auto_page_enable_nxt = i_sfr_wdata[`SPSC_EN_BIT];
            stack_level_index_nxt = i_sfr_wdata[`SPSC_IDX_HI:`SPSC_IDX_LO];
        end
    end

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            auto_page_enable_r <= `SPSC_EN_RESET;
            stack_level_index_r <= `SPSC_IDX_RESET;
        end else begin
            auto_page_enable_r <= auto_page_enable_nxt;
            stack_level_index_r <= stack_level_index_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Page and stack
    // ----------------------------------------------------------------
    // A software page write in the cycle of an enabled entry or return is lost:
    // the core vectors before that write would land.
    always @* begin
        page_nxt = page_r;
        lvl_nxt = lvl_r;
        if (push_ev) begin
            lvl_nxt = push_levels(lvl_r, page_r);
            page_nxt = i_isr_page;
        end else if (pop_ev) begin
            lvl_nxt = pop_levels(lvl_r);
            page_nxt = lvl_r[W-1:0];
        end else if (page_wr) begin
            page_nxt = i_sfr_wdata[W-1:0];
        end
    end

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            page_r <= `SPSC_PAGE_RESET;
        end else begin
            page_r <= page_nxt;
        end
    end

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            lvl_r <= {STORED{`SPSC_PAGE_RESET}};
        end else begin
            lvl_r <= lvl_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Data is forced to zero outside a read so that a shared read bus
    // can simply OR the answers of all blocks.
    always @* begin
        rdata_nxt = 8'h00;
        hit_nxt = 1'b0;
        if (i_sfr_rd) begin
            if (hit_ctrl) begin
                rdata_nxt = ctrl_byte(auto_page_enable_r, stack_level_index_r);
                hit_nxt = 1'b1;
            end else if (hit_read) begin
                rdata_nxt = level_sel;
                hit_nxt = 1'b1;
            end else if (hit_page) begin
                rdata_nxt = page_r;
                hit_nxt = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sfr_rdata <= 8'h00;
            o_sfr_hit <= 1'b0;
        end else begin
            o_sfr_rdata <= rdata_nxt;
            o_sfr_hit <= hit_nxt;
        end
    end

    // Mirrors lag the internal state by one cycle
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_current_page_select <= `SPSC_PAGE_RESET;
            o_auto_page_enable <= `SPSC_EN_RESET;
        end else begin
            o_current_page_select <= page_r;
            o_auto_page_enable <= auto_page_enable_r;
        end
    end
endmodule // spsc_page_stack

// [dv/spsc_core_model.sv]
// Core-side model: interrupt entry and return pulses with the source page.
// Assumes callers invoke evt just after a rising clock edge.
`timescale 1ns/1ps
module spsc_core_model (
    input wire i_clk_sys,
    output reg o_isr_enter = 1'b0,
    output reg o_isr_return = 1'b0,
    output reg [7:0] o_isr_page = 8'h00
);
    // Page means nothing without an entry, so it toggles to expose stale use
    task evt(input e, input r, input [7:0] p);
        begin
            o_isr_enter <= e;
            o_isr_return <= r;
            o_isr_page <= e ? p : ~o_isr_page;
            @(posedge i_clk_sys);
        end
    endtask
endmodule // spsc_core_model

// [dv/spsc_page_stack_monitor.sv]
// Checker bound to the page stack block ports.
// Assumes outputs settle one cycle after the taking edge.
`timescale 1ns/1ps
module spsc_page_stack_monitor #(
    parameter W = 8
) (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire [7:0] i_sfr_addr,
    input wire i_sfr_wr,
    input wire i_sfr_rd,
    input wire [7:0] i_sfr_wdata,
    input wire i_isr_enter,
    input wire [W-1:0] i_isr_page,
    input wire i_isr_return,
    input wire [7:0] o_sfr_rdata,
    input wire o_sfr_hit,
    input wire [W-1:0] o_current_page_select,
    input wire o_auto_page_enable
);
    reg cw_d;
    wire cw = i_sfr_wr && i_sfr_addr == 8'hcf;
    wire pw = i_sfr_wr && i_sfr_addr == 8'ha7;
    wire ev = i_isr_enter || i_isr_return || pw;
    // Enable output lags a cycle, so a control write just before hides it
    wire en = o_auto_page_enable && !cw_d;
    always @(posedge i_clk_sys) cw_d <= cw;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    a_entry_page: assert property (i_isr_enter && en ##1 !ev
        |=> o_current_page_select == $past(i_isr_page, 2)) else $error("entry page");
    a_paging_off: assert property ((i_isr_enter || i_isr_return) && !en && !cw_d && !pw
        |=> ##1 $stable(o_current_page_select)) else $error("page moved");
    a_return_pop: assert property (i_isr_enter && en && !cw ##1 i_isr_return && !i_isr_enter
        |=> ##1 o_current_page_select == $past(o_current_page_select, 2)) else $error("pop");
    a_ctrl_read: assert property (cw ##1 i_sfr_rd && !i_sfr_wr && i_sfr_addr == 8'hcf
        |=> o_sfr_hit && o_sfr_rdata == ($past(i_sfr_wdata, 2) & 8'h71)) else $error("ctrl");
    a_enable_copy: assert property (cw ##1 !cw
        |=> o_auto_page_enable == |($past(i_sfr_wdata, 2) & 8'h01)) else $error("enable");
    a_readout_gate: assert property (i_sfr_rd && i_sfr_addr == 8'hd3 && !ev
        |=> o_sfr_hit == (o_current_page_select == 8'h0f)) else $error("readout hit");
    a_unmapped_read: assert property (i_sfr_rd && i_sfr_addr != 8'hcf && i_sfr_addr != 8'ha7
        && i_sfr_addr != 8'hd3 |=> !o_sfr_hit && o_sfr_rdata == 8'h00) else $error("unmapped");
    a_read_idle: assert property (!i_sfr_rd |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
        else $error("idle data");
endmodule // spsc_page_stack_monitor

// [dv/spsc_page_stack_tb.sv]
// Testbench for the page stack block: SFR accesses plus core entry/return.
// Assumes all design outputs are registered on the rising edge.
`timescale 1ns/1ps
module spsc_page_stack_tb;
    reg i_clk_sys = 1'b0, i_rstn = 1'b0, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
    reg [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
    wire i_isr_enter, i_isr_return, o_sfr_hit, o_auto_page_enable;
    wire [7:0] i_isr_page, o_sfr_rdata, o_current_page_select;
    integer err_count = 0, samples_checked = 0, i;
    always #10 i_clk_sys = ~i_clk_sys;
    spsc_page_stack #(.W(8)) uut (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_sfr_addr(i_sfr_addr),
        .i_sfr_wr(i_sfr_wr),
        .i_sfr_rd(i_sfr_rd),
        .i_sfr_wdata(i_sfr_wdata),
        .i_isr_enter(i_isr_enter),
        .i_isr_page(i_isr_page),
        .i_isr_return(i_isr_return),
        .o_sfr_rdata(o_sfr_rdata),
        .o_sfr_hit(o_sfr_hit),
        .o_current_page_select(o_current_page_select),
        .o_auto_page_enable(o_auto_page_enable)
    );
    spsc_core_model core (.i_clk_sys(i_clk_sys), .o_isr_enter(i_isr_enter),
        .o_isr_return(i_isr_return), .o_isr_page(i_isr_page));
    task chk(input [8:0] got, input [8:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    // No trailing release edge: callers never issue two writes in a row
    task wr(input [7:0] a, input [7:0] d);
        begin
            i_sfr_wr <= 1'b1; i_sfr_addr <= a; i_sfr_wdata <= d;
            @(posedge i_clk_sys);
            i_sfr_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [8:0] e);
        begin
            i_sfr_rd <= 1'b1; i_sfr_addr <= a;
            @(posedge i_clk_sys);
            i_sfr_rd <= 1'b0;
            @(posedge i_clk_sys);
            chk({o_sfr_hit, o_sfr_rdata}, e);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d errors %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        #100000;
        err_count = err_count + 1;
        wrap_up;
    end
    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        @(posedge i_clk_sys);
        rd(8'hcf, 9'h101);
        wr(8'hcf, 8'h71);
        rd(8'hcf, 9'h171);
        wr(8'ha7, 8'h11);
        for (i = 2; i < 7; i = i + 1) core.evt(1'b1, 1'b0, (i == 6) ? 8'h0f : 8'h10 + i[7:0]);
        core.evt(1'b0, 1'b0, 8'h00);
        rd(8'ha7, 9'h10f);
        for (i = 0; i < 7; i = i + 1) begin
            wr(8'hcf, {1'b0, i[2:0], 4'h1});
            rd(8'hd3, {1'b1, (i == 0) ? 8'h0f : (i < 5) ? 8'h16 - i[7:0] : 8'h00});
        end
        core.evt(1'b0, 1'b1, 8'h00);
        core.evt(1'b0, 1'b0, 8'h00);
        rd(8'ha7, 9'h115);
        rd(8'hd3, 9'h000);
        core.evt(1'b1, 1'b0, 8'h22);
        core.evt(1'b0, 1'b1, 8'h00);
        core.evt(1'b0, 1'b0, 8'h00);
        rd(8'ha7, 9'h115);
        wr(8'hcf, 8'h00);
        rd(8'hcf, 9'h100);
        core.evt(1'b1, 1'b0, 8'h33);
        core.evt(1'b0, 1'b1, 8'h00);
        core.evt(1'b0, 1'b0, 8'h00);
        rd(8'ha7, 9'h115);
        rd(8'h80, 9'h000);
        wrap_up;
    end
endmodule // spsc_page_stack_tb
bind spsc_page_stack spsc_page_stack_monitor #(.W(W)) mon (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr),
    .i_sfr_rd(i_sfr_rd),
    .i_sfr_wdata(i_sfr_wdata),
    .i_isr_enter(i_isr_enter),
    .i_isr_page(i_isr_page),
    .i_isr_return(i_isr_return),
    .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit),
    .o_current_page_select(o_current_page_select),
    .o_auto_page_enable(o_auto_page_enable)
);
